// ---- core/psmb_pkg.sv ----
package psmb_pkg;

  // clock and bus timing
  localparam int CLK_KHZ = 25000;
  localparam int F_SCL_MAX_KHZ = 100;
  localparam int T_STRETCH_US = 1000;
  localparam int STRETCH_CYC = T_STRETCH_US * CLK_KHZ / 1000;
  localparam int T_TIMEOUT_US = 25000;
  localparam int TIMEOUT_CYC = T_TIMEOUT_US * CLK_KHZ / 1000;
  localparam int T_SUDAT_NS = 250;
  localparam int SUDAT_CYC = (T_SUDAT_NS * CLK_KHZ + 999999) / 1000000;

  // target addresses, 7-bit form
  localparam logic [6:0] ADDR_CTRL_BASE = 7'h58;
  localparam logic [6:0] ADDR_EEP_BASE = 7'h50;
  localparam int RW_BIT = 0;

  // command and framing values
  localparam logic [7:0] WP_CMD = 8'h10;
  localparam int WP_FLAG_BIT = 0;
  localparam logic WP_RESET = 1'b1;
  localparam logic [7:0] BLK_MAX = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // user storage
  localparam int EEP_DEPTH = 32768;
  localparam int PAGE_W = 5;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_RX      = 3'h1,
    ST_RACK    = 3'h3,
    ST_TX      = 3'h2,
    ST_TACK    = 3'h6,
    ST_STRETCH = 3'h7,
    ST_SETUP   = 3'h5
  } psmb_state_t;

endpackage : psmb_pkg

// ---- core/psmb_eep_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface psmb_eep_if #(
  parameter int AW = 15
);
  logic we;
  logic wp;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport engine (output we, output wp, output waddr, output raddr, output wdata, input rdata);
  modport store (input we, input wp, input waddr, input raddr, input wdata, output rdata);
endinterface : psmb_eep_if
`default_nettype wire

// ---- core/psmb_eep_store.sv ----
`timescale 1ns/1ps
`default_nettype none
module psmb_eep_store #(
  parameter int DEPTH = psmb_pkg::EEP_DEPTH,
  parameter int AW = 15
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // engine side
  psmb_eep_if.store eep
);

  logic [7:0] mem [DEPTH];

  if (DEPTH != (1 << AW)) begin : g_chk
    $error("psmb_eep_store: DEPTH must equal 2**AW");
  end

  // user storage only, nothing else in the supply touches it
  always_ff @(posedge clk_sys) begin
    if (ce && eep.we && !eep.wp) begin
      mem[eep.waddr] <= eep.wdata;
    end
  end

  assign eep.rdata = mem[eep.raddr];

  // helpers for the protection check
  logic chk_hit_q;
  logic [AW-1:0] chk_addr_q;
  logic [7:0] chk_old_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chk_hit_q <= 1'b0;
      chk_addr_q <= '0;
      chk_old_q <= 8'h00;
    end else begin
      chk_hit_q <= ce && eep.we && eep.wp;
      chk_addr_q <= eep.waddr;
      chk_old_q <= mem[eep.waddr];
    end
  end

  property p_protect;
    @(posedge clk_sys) disable iff (!rst_n)
      chk_hit_q |-> mem[chk_addr_q] == chk_old_q;
  endproperty
  a_protect: assert property (p_protect) else $error("protected byte changed");

  property p_wr_open;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && eep.we && !eep.wp;
  endproperty
  c_wr_open: cover property (p_wr_open);

endmodule : psmb_eep_store
`default_nettype wire

// ---- core/psmb_target.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - target only; never drives a start condition or begins a transfer.
// - bus runs up to 100 kbps; slower rates accepted while each SCL low phase stays under 25 ms.
// - own clock stretch releases SCL within 1 ms.
// - SCL low over 25 ms aborts transfer; ready again within 10 ms.
// - alert is the OR of all shutdown and warning events.
// - alert is active low and idles high.
// - controller and storage answer as two targets on one bus.
// - select index sets addresses 0xB0 and 0xA0 plus twice the index.
// - storage write protection is on after power-up.
// - 32K bytes of user storage, never used by the supply itself.
// - storage address is 16 bits, high byte first, each acknowledged.
// - storage write: address, two address bytes, data bytes, stop.
// - storage read: address bytes, repeated start, read bytes, final nack.
// - storage page writes limited to 32 bytes per page.
// - first byte after controller address is a command code.
// - start and stop recognised anywhere and resynchronise the engine.
// - controller write may end after command, one, or two data bytes.
// - block writes of at most 255 bytes accepted.
// - controller reads return a byte or a word after repeated start.
// - block reads return at most 255 bytes.
module psmb_target #(
  parameter int STRETCH_CYC = psmb_pkg::STRETCH_CYC,
  parameter int TIMEOUT_CYC = psmb_pkg::TIMEOUT_CYC,
  parameter int SD_W = 4,
  parameter int WN_W = 4,
  parameter int EEP_DEPTH = psmb_pkg::EEP_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // two-wire bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // address select straps
  input wire logic addr_sel_bit2,
  input wire logic addr_sel_bit1,
  input wire logic addr_sel_bit0,
  // supply events and alert
  input wire logic [SD_W-1:0] shutdown_evt,
  input wire logic [WN_W-1:0] warning_evt,
  output logic fault_alert_n,
  // command stream to the supply controller
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic [7:0] wr_index,
  output logic wr_done,
  output logic rd_req,
  output logic [7:0] rd_index,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  // status
  output logic wp_active
);

  localparam int EAW = $clog2(EEP_DEPTH);
  localparam int SW = $clog2(STRETCH_CYC + 1);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int STR_LIM = STRETCH_CYC - psmb_pkg::SUDAT_CYC - 2;

  if (STR_LIM < 1 || TIMEOUT_CYC < 2 || EAW < 6 || EAW > 16 ||
      psmb_pkg::CLK_KHZ < 20 * psmb_pkg::F_SCL_MAX_KHZ) begin : g_chk
    $error("psmb_target: parameters out of range");
  end

  function automatic logic [6:0] tgt_addr(input logic [6:0] base, input logic [2:0] sel);
    tgt_addr = base + {4'h0, sel};
  endfunction : tgt_addr

  // pin synchronisers
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic [2:0] asel_m_q, asel_s_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      asel_m_q <= 3'h0;
      asel_s_q <= 3'h0;
    end else if (ce) begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      asel_m_q <= {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
      asel_s_q <= asel_m_q;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_c = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_c = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  // protocol engine
  psmb_pkg::psmb_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, idx_q, idx_d, rcnt_q, rcnt_d, cmd_q, cmd_d;
  logic [15:0] ea_q, ea_d;
  logic first_q, first_d, selc_q, selc_d, sele_q, sele_d, rd_q, rd_d;
  logic wp_q, wp_d, sdaoe_q, sdaoe_d, scloe_q, scloe_d, ack_q, ack_d;
  logic [SW-1:0] scnt_q, scnt_d;
  logic [TW-1:0] tcnt_q, tcnt_d;
  logic cmdv_q, cmdv_d, wrv_q, wrv_d, wrdone_q, wrdone_d, rdreq_q, rdreq_d;
  logic [7:0] wrdat_q, wrdat_d, wridx_q, wridx_d, rdidx_q, rdidx_d;
  logic we_c, need_load, to_hit, ctrl_wr;
  logic [7:0] tx_byte;
  psmb_eep_if #(.AW(EAW)) eep_bus ();

  assign to_hit = !scl_s_q && st_q != psmb_pkg::ST_IDLE && tcnt_q == TW'(TIMEOUT_CYC - 1);
  assign ctrl_wr = selc_q && !rd_q;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    idx_d = idx_q;
    rcnt_d = rcnt_q;
    cmd_d = cmd_q;
    ea_d = ea_q;
    first_d = first_q;
    selc_d = selc_q;
    sele_d = sele_q;
    rd_d = rd_q;
    wp_d = wp_q;
    sdaoe_d = sdaoe_q;
    scloe_d = scloe_q;
    ack_d = ack_q;
    scnt_d = scnt_q;
    cmdv_d = 1'b0;
    wrv_d = 1'b0;
    wrdone_d = 1'b0;
    rdreq_d = 1'b0;
    wrdat_d = wrdat_q;
    wridx_d = wridx_q;
    rdidx_d = rdidx_q;
    we_c = 1'b0;
    need_load = 1'b0;
    tx_byte = psmb_pkg::IDLE_BYTE;
    tcnt_d = (scl_s_q || st_q == psmb_pkg::ST_IDLE) ? '0 : tcnt_q + 1'b1;
    if (to_hit) begin
      st_d = psmb_pkg::ST_IDLE;
      sdaoe_d = 1'b0;
      scloe_d = 1'b0;
      selc_d = 1'b0;
      sele_d = 1'b0;
      tcnt_d = '0;
    end else if (start_c || stop_c) begin
      wrdone_d = ctrl_wr && !first_q;
      st_d = start_c ? psmb_pkg::ST_RX : psmb_pkg::ST_IDLE;
      bit_d = 4'h0;
      first_d = start_c;
      selc_d = 1'b0;
      sele_d = 1'b0;
      sdaoe_d = 1'b0;
      scloe_d = 1'b0;
    end else begin
      case (st_q)
        psmb_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s_q};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == psmb_pkg::BITS_PER_BYTE) begin
            bit_d = 4'h0;
            st_d = psmb_pkg::ST_RACK;
            sdaoe_d = 1'b1;
            if (first_q) begin
              first_d = 1'b0;
              idx_d = 8'h00;
              rcnt_d = 8'h00;
              rd_d = sh_q[psmb_pkg::RW_BIT];
              if (sh_q[7:1] == tgt_addr(psmb_pkg::ADDR_CTRL_BASE, asel_s_q)) begin
                selc_d = 1'b1;
              end else if (sh_q[7:1] == tgt_addr(psmb_pkg::ADDR_EEP_BASE, asel_s_q)) begin
                sele_d = 1'b1;
              end else begin
                st_d = psmb_pkg::ST_IDLE;
                sdaoe_d = 1'b0;
              end
            end else if (selc_q) begin
              idx_d = idx_q + 8'h01;
              if (idx_q == 8'h00) begin
                cmd_d = sh_q;
                cmdv_d = 1'b1;
              end else if (idx_q == psmb_pkg::BLK_MAX) begin
                idx_d = idx_q;
                st_d = psmb_pkg::ST_IDLE;
                sdaoe_d = 1'b0;
              end else begin
                wrv_d = 1'b1;
                wrdat_d = sh_q;
                wridx_d = idx_q;
                if (cmd_q == psmb_pkg::WP_CMD && idx_q == 8'h01) begin
                  wp_d = sh_q[psmb_pkg::WP_FLAG_BIT];
                end
              end
            end else begin
              idx_d = (idx_q == psmb_pkg::BLK_MAX) ? idx_q : idx_q + 8'h01;
              if (idx_q == 8'h00) begin
                ea_d[15:8] = sh_q;
              end else if (idx_q == 8'h01) begin
                ea_d[7:0] = sh_q;
              end else begin
                we_c = 1'b1;
                ea_d[psmb_pkg::PAGE_W-1:0] = ea_q[psmb_pkg::PAGE_W-1:0] + 1'b1;
              end
            end
          end
        end
        psmb_pkg::ST_RACK: begin
          if (scl_fall) begin
            sdaoe_d = 1'b0;
            st_d = psmb_pkg::ST_RX;
            need_load = rd_q;
          end
        end
        psmb_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == psmb_pkg::BITS_PER_BYTE) begin
              sdaoe_d = 1'b0;
              bit_d = 4'h0;
              ack_d = 1'b0;
              st_d = psmb_pkg::ST_TACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sdaoe_d = !sh_q[6];
            end
          end
        end
        psmb_pkg::ST_TACK: begin
          if (scl_rise) begin
            ack_d = !sda_s_q;
          end else if (scl_fall) begin
            need_load = ack_q;
            st_d = psmb_pkg::ST_IDLE;
          end
        end
        psmb_pkg::ST_STRETCH: begin
          scnt_d = scnt_q + 1'b1;
          if (rd_valid || scnt_q == SW'(STR_LIM)) begin
            sh_d = rd_valid ? rd_data : psmb_pkg::IDLE_BYTE;
            sdaoe_d = rd_valid ? !rd_data[7] : 1'b0;
            scnt_d = '0;
            st_d = psmb_pkg::ST_SETUP;
          end
        end
        psmb_pkg::ST_SETUP: begin
          scnt_d = scnt_q + 1'b1;
          if (scnt_q == SW'(psmb_pkg::SUDAT_CYC - 1)) begin
            scloe_d = 1'b0;
            bit_d = 4'h0;
            st_d = psmb_pkg::ST_TX;
          end
        end
        default: begin
          st_d = psmb_pkg::ST_IDLE;
        end
      endcase
      if (need_load) begin
        bit_d = 4'h0;
        if (selc_q && rcnt_q != psmb_pkg::BLK_MAX) begin
          rdreq_d = 1'b1;
          rdidx_d = rcnt_q;
          rcnt_d = rcnt_q + 8'h01;
          scloe_d = 1'b1;
          scnt_d = '0;
          st_d = psmb_pkg::ST_STRETCH;
        end else begin
          if (sele_q) begin
            tx_byte = eep_bus.rdata;
            ea_d = ea_q + 16'h0001;
          end
          sh_d = tx_byte;
          sdaoe_d = !tx_byte[7];
          st_d = psmb_pkg::ST_TX;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= psmb_pkg::ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 8'h00;
      rcnt_q <= 8'h00;
      cmd_q <= 8'h00;
      ea_q <= 16'h0000;
      first_q <= 1'b0;
      selc_q <= 1'b0;
      sele_q <= 1'b0;
      rd_q <= 1'b0;
      wp_q <= psmb_pkg::WP_RESET;
      sdaoe_q <= 1'b0;
      scloe_q <= 1'b0;
      ack_q <= 1'b0;
      scnt_q <= '0;
      tcnt_q <= '0;
      cmdv_q <= 1'b0;
      wrv_q <= 1'b0;
      wrdone_q <= 1'b0;
      rdreq_q <= 1'b0;
      wrdat_q <= 8'h00;
      wridx_q <= 8'h00;
      rdidx_q <= 8'h00;
    end else if (ce) begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      idx_q <= idx_d;
      rcnt_q <= rcnt_d;
      cmd_q <= cmd_d;
      ea_q <= ea_d;
      first_q <= first_d;
      selc_q <= selc_d;
      sele_q <= sele_d;
      rd_q <= rd_d;
      wp_q <= wp_d;
      sdaoe_q <= sdaoe_d;
      scloe_q <= scloe_d;
      ack_q <= ack_d;
      scnt_q <= scnt_d;
      tcnt_q <= tcnt_d;
      cmdv_q <= cmdv_d;
      wrv_q <= wrv_d;
      wrdone_q <= wrdone_d;
      rdreq_q <= rdreq_d;
      wrdat_q <= wrdat_d;
      wridx_q <= wridx_d;
      rdidx_q <= rdidx_d;
    end
  end

  // alert output
  logic any_evt, alert_q, alert_d;
  assign any_evt = (|shutdown_evt) || (|warning_evt);
  always_comb begin
    alert_d = !any_evt;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alert_q <= 1'b1;
    end else if (ce) begin
      alert_q <= alert_d;
    end
  end

  // storage
  assign eep_bus.we = we_c;
  assign eep_bus.wp = wp_q;
  assign eep_bus.waddr = ea_q[EAW-1:0];
  assign eep_bus.raddr = ea_q[EAW-1:0];
  assign eep_bus.wdata = sh_q;

  psmb_eep_store #(.DEPTH(EEP_DEPTH), .AW(EAW)) u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .eep(eep_bus)
  );

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scloe_q;
  assign sda_oe = sdaoe_q;
  assign fault_alert_n = alert_q;
  assign cmd_valid = cmdv_q;
  assign cmd_code = cmd_q;
  assign wr_valid = wrv_q;
  assign wr_data = wrdat_q;
  assign wr_index = wridx_q;
  assign wr_done = wrdone_q;
  assign rd_req = rdreq_q;
  assign rd_index = rdidx_q;
  assign wp_active = wp_q;

  // checks
  logic [SW:0] hold_q;
  logic [10:0] ea_hi;
  assign ea_hi = ea_q[15:5];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (ce) begin
      hold_q <= scloe_q ? hold_q + 1'b1 : '0;
    end
  end

  property p_no_start;
    @(posedge clk_sys) disable iff (!rst_n)
      sdaoe_q |-> (st_q == psmb_pkg::ST_RACK || st_q == psmb_pkg::ST_TX || st_q == psmb_pkg::ST_SETUP);
  endproperty
  a_no_start: assert property (p_no_start) else $error("sda driven outside ack or data");
  property p_stretch;
    @(posedge clk_sys) disable iff (!rst_n)
      scloe_q |-> hold_q < (SW+1)'(STRETCH_CYC);
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl held too long");
  property p_timeout;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && to_hit) |=> st_q == psmb_pkg::ST_IDLE && !sdaoe_q && !scloe_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not taken");
  property p_alert;
    @(posedge clk_sys) disable iff (!rst_n)
      ce |=> fault_alert_n == !$past(any_evt);
  endproperty
  a_alert: assert property (p_alert) else $error("alert wrong");
  property p_alert_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && !any_evt) ##1 !any_evt |-> fault_alert_n;
  endproperty
  a_alert_idle: assert property (p_alert_idle) else $error("alert low without event");
  property p_addr;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && st_q == psmb_pkg::ST_RX && first_q && scl_fall && bit_q == psmb_pkg::BITS_PER_BYTE &&
       sh_q[7:1] == tgt_addr(psmb_pkg::ADDR_EEP_BASE, asel_s_q)) |=> st_q == psmb_pkg::ST_RACK && sele_q && sdaoe_q;
  endproperty
  a_addr: assert property (p_addr) else $error("storage address not acknowledged");
  property p_wp_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(rst_n) |-> wp_q;
  endproperty
  a_wp_reset: assert property (p_wp_reset) else $error("protection off after reset");
  property p_page;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && we_c) |=> ea_hi == $past(ea_hi);
  endproperty
  a_page: assert property (p_page) else $error("write crossed page");
  property p_cmd;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && st_q == psmb_pkg::ST_RX && !first_q && ctrl_wr && idx_q == 8'h00 && scl_fall &&
       bit_q == psmb_pkg::BITS_PER_BYTE) |=> cmd_valid && cmd_code == $past(sh_q);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command byte not reported");
  property p_resync;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && start_c && !to_hit) |=> st_q == psmb_pkg::ST_RX && bit_q == 4'h0 && first_q && !sdaoe_q;
  endproperty
  a_resync: assert property (p_resync) else $error("start not resynchronised");

  c_ctrl_read: cover property (@(posedge clk_sys) disable iff (!rst_n) rdreq_q ##[1:300] rd_valid);
  c_word_write: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_done && wr_index == 8'h02);
  c_timeout: cover property (@(posedge clk_sys) disable iff (!rst_n) ce && to_hit);

endmodule : psmb_target
`default_nettype wire

// ---- tb/psmb_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module psmb_host_model (
  // clock
  input wire logic clk_sys,
  // bus wires
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic hang
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // release scl, wait out a stretch, then hold high 4 cycles
  task automatic rise();
    int k;
    k = 0;
    scl_low <= 1'b0;
    tick(1);
    while (scl !== 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
    if (k >= 1000) hang <= 1'b1;
    tick(3);
  endtask : rise

  task automatic bit_io(input logic b, output logic s);
    sda_low <= ~b;
    tick(3);
    rise();
    s = sda;
    scl_low <= 1'b1;
    tick(1);
  endtask : bit_io

  task automatic start();
    sda_low <= 1'b0;
    tick(3);
    rise();
    sda_low <= 1'b1;
    tick(4);
    scl_low <= 1'b1;
    tick(1);
  endtask : start

  task automatic stop();
    sda_low <= 1'b1;
    tick(3);
    rise();
    sda_low <= 1'b0;
    tick(8);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask : rbyte
endmodule : psmb_host_model
`default_nettype wire

// ---- tb/psu_smbus_target_iface_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module psu_smbus_target_iface_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [3:0] shutdown_evt = 4'h0;
  logic [3:0] warning_evt = 4'h0;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic resp_on = 1'b1;
  logic ce = 1'b1;
  logic scl_o_w, sda_o_w;
  logic scl_oe, sda_oe, fault_alert_n, cmd_valid, wr_valid, wr_done, rd_req, wp_active;
  logic scl_low, sda_low, hang;
  logic [7:0] cmd_code, wr_data, wr_index, rd_index;
  wire logic scl;
  wire logic sda;
  int n_fail = 0;
  int samples_checked = 0;
  int n_cmd = 0;
  int n_wr = 0;
  int n_done = 0;
  int rd_cnt = 0;
  assign scl = ~(scl_low | scl_oe);
  assign sda = ~(sda_low | sda_oe);

  always #20 clk_sys = ~clk_sys;

  psmb_target #(.STRETCH_CYC(200), .TIMEOUT_CYC(2000)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .scl_i(scl), .scl_o(scl_o_w), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o_w), .sda_oe(sda_oe),
    .addr_sel_bit2(sel[2]), .addr_sel_bit1(sel[1]), .addr_sel_bit0(sel[0]),
    .shutdown_evt(shutdown_evt), .warning_evt(warning_evt), .fault_alert_n(fault_alert_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_index(wr_index), .wr_done(wr_done), .rd_req(rd_req), .rd_index(rd_index),
    .rd_valid(rd_valid), .rd_data(rd_data), .wp_active(wp_active)
  );

  psmb_host_model host (
    .clk_sys(clk_sys), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low), .hang(hang)
  );

  // pulse counters and a slow read-data source
  always @(posedge clk_sys) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (wr_valid === 1'b1) n_wr++;
    if (wr_done === 1'b1) n_done++;
    rd_valid <= 1'b0;
    if (rd_req === 1'b1 && resp_on) begin
      rd_cnt <= 12;
    end else if (rd_cnt != 0) begin
      rd_cnt <= rd_cnt - 1;
      if (rd_cnt == 1) begin
        rd_valid <= 1'b1;
        rd_data <= 8'hc0 + rd_index;
      end
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge hang) begin
    n_fail++;
    tally_and_finish();
  end

  task automatic wb(input logic [7:0] d);
    logic a;
    host.wbyte(d, a);
    check(a, 1'b1);
  endtask : wb

  task automatic probe(input logic [7:0] adr, input logic exp);
    logic a;
    host.start();
    host.wbyte(adr, a);
    host.stop();
    check(a, exp);
  endtask : probe

  task automatic ctl_write(input logic [7:0] cmd, input int n, input logic [7:0] d0, input logic [7:0] d1);
    host.start();
    wb(8'hb0);
    wb(cmd);
    if (n > 0) wb(d0);
    if (n > 1) wb(d1);
    host.stop();
  endtask : ctl_write

  task automatic ee_write(input logic [15:0] adr, input int n, input logic [7:0] d0, input logic [7:0] d1);
    host.start();
    wb(8'ha0);
    wb(adr[15:8]);
    wb(adr[7:0]);
    wb(d0);
    if (n > 1) wb(d1);
    host.stop();
  endtask : ee_write

  task automatic ee_read(input logic [15:0] adr, output logic [7:0] d);
    host.start();
    wb(8'ha0);
    wb(adr[15:8]);
    wb(adr[7:0]);
    host.start();
    wb(8'ha1);
    host.rbyte(1'b1, d);
    host.stop();
  endtask : ee_read

  task automatic t_alert();
    for (int i = 0; i < 8; i++) begin
      {warning_evt, shutdown_evt} <= 8'h01 << i;
      host.tick(3);
      check(fault_alert_n, 1'b0);
      {warning_evt, shutdown_evt} <= 8'h00;
      host.tick(3);
      check(fault_alert_n, 1'b1);
    end
    // clock enable low freezes the alert flop
    ce <= 1'b0;
    shutdown_evt <= 4'h1;
    host.tick(3);
    check(fault_alert_n, 1'b1);
    ce <= 1'b1;
    host.tick(3);
    check(fault_alert_n, 1'b0);
    shutdown_evt <= 4'h0;
    host.tick(3);
    check(fault_alert_n, 1'b1);
  endtask : t_alert

  task automatic t_addr();
    for (int i = 0; i < 8; i++) begin
      sel <= i[2:0];
      host.tick(8);
      probe(8'hb0 + 8'(2 * i), 1'b1);
      probe(8'ha0 + 8'(2 * i), 1'b1);
      probe(8'hb0 + 8'(2 * ((i + 1) % 8)), 1'b0);
    end
    sel <= 3'h0;
    host.tick(8);
  endtask : t_addr

  task automatic t_ctl_write();
    int c0;
    int w0;
    int e0;
    // counts taken relative to here: address-only probes also end a write
    c0 = n_cmd;
    w0 = n_wr;
    e0 = n_done;
    ctl_write(8'h3c, 2, 8'ha5, 8'h5a);
    check({4'(n_cmd - c0), 4'(n_wr - w0), 4'(n_done - e0)}, 12'h121);
    check({cmd_code, wr_data}, 16'h3c5a);
    check(wr_index, 8'h02);
    ctl_write(8'h3d, 0, 8'h00, 8'h00);
    check({4'(n_cmd - c0), 4'(n_wr - w0), cmd_code}, 16'h223d);
  endtask : t_ctl_write

  task automatic t_blk_write();
    logic a;
    host.start();
    wb(8'hb0);
    wb(8'h3e);
    for (int i = 1; i < 255; i++) wb(8'(i));
    host.wbyte(8'h55, a);
    host.stop();
    check({wr_index, 7'h00, a}, 16'hfe00);
  endtask : t_blk_write

  task automatic t_eeprom();
    logic [7:0] d;
    ctl_write(psmb_pkg::WP_CMD, 1, 8'h00, 8'h00);
    check(wp_active, 1'b0);
    ee_write(16'h0123, 1, 8'h11, 8'h00);
    ee_read(16'h0123, d);
    check(d, 8'h11);
    ee_write(16'h2a1f, 2, 8'h66, 8'h77);
    ee_read(16'h2a00, d);
    check(d, 8'h77);
    ee_read(16'h2a1f, d);
    check(d, 8'h66);
    ee_write(16'h7fff, 1, 8'h3e, 8'h00);
    ee_read(16'h7fff, d);
    check(d, 8'h3e);
    ctl_write(psmb_pkg::WP_CMD, 1, 8'h01, 8'h00);
    check(wp_active, 1'b1);
    ee_write(16'h0123, 1, 8'h22, 8'h00);
    ee_read(16'h0123, d);
    check(d, 8'h11);
  endtask : t_eeprom

  task automatic t_ctl_read();
    logic [7:0] d0;
    logic [7:0] d1;
    host.start();
    wb(8'hb0);
    wb(8'h8b);
    host.start();
    wb(8'hb1);
    host.rbyte(1'b0, d0);
    host.rbyte(1'b1, d1);
    host.stop();
    check({d0, d1}, 16'hc0c1);
    check(rd_index, 8'h01);
    resp_on <= 1'b0;
    host.start();
    wb(8'hb1);
    host.rbyte(1'b1, d0);
    host.stop();
    check(d0, 8'hff);
    resp_on <= 1'b1;
  endtask : t_ctl_read

  task automatic t_timeout();
    logic s;
    logic [7:0] adr = 8'hb0;
    host.start();
    for (int i = 7; i >= 0; i--) host.bit_io(adr[i], s);
    host.tick(8);
    check(sda_oe, 1'b1);
    host.tick(2100);
    check({scl_oe, sda_oe}, 2'b00);
    host.stop();
    probe(8'hb0, 1'b1);
  endtask : t_timeout

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    host.tick(4);
    check({fault_alert_n, wp_active, scl_oe, sda_oe}, 4'b1100);
    check({scl_o_w, sda_o_w}, 2'b00);
    t_alert();
    t_addr();
    t_ctl_write();
    t_blk_write();
    t_eeprom();
    t_ctl_read();
    t_timeout();
    tally_and_finish();
  end
endmodule : psu_smbus_target_iface_test
`default_nettype wire
